//--- core/jst_table.sv
// jog speed table: AXI4-Lite register file, flash copy, jog speed selection
// assumes asynchronous selection and jog pins, one aclk domain, aresetn as power-up
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "jst_regs.svh"
module jst_table #(
   parameter int N = `JST_NUM_ENTRIES,
   parameter int NV_WORD_CYC = `JST_NV_WORD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic flash_por_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic speed_select_bit0,
   input wire logic speed_select_bit1,
   input wire logic speed_select_bit2,
   input wire logic jog_forward_cmd,
   input wire logic jog_reverse_cmd,
   input wire logic home_cmd,
   input wire logic mode0_sel,
   output logic [2:0] jog_speed_index,
   output logic [31:0] jog_speed_target,
   output logic [31:0] jog_velocity_cmd,
   output logic [31:0] jog_ramp_rate,
   output logic jog_active
);
   initial begin
      if (N != 8 || NV_WORD_CYC < 1) $error("jst_table: table must have eight entries");
   end
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLV = 2'h2;
   localparam logic [1:0] RESP_DEC = 2'h3;

   // ==========================================
   // decoding shared by read and write paths
   function automatic jst_pkg::jst_region_t region_of(input logic [7:0] a);
      if (a[1:0] != 2'b00) return jst_pkg::JST_R_NONE;
      if (a < `JST_OFF_WORK) return jst_pkg::JST_R_STAGE;
      if (a < `JST_OFF_CMD) return jst_pkg::JST_R_WORK;
      case (a)
         `JST_OFF_CMD: return jst_pkg::JST_R_CMD;
         `JST_OFF_STATUS: return jst_pkg::JST_R_STATUS;
         `JST_OFF_ACTIVE: return jst_pkg::JST_R_ACTIVE;
         `JST_OFF_ACCEL: return jst_pkg::JST_R_ACCEL;
         `JST_OFF_DECEL: return jst_pkg::JST_R_DECEL;
         default: return jst_pkg::JST_R_NONE;
      endcase
   endfunction : region_of

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction : merge

   function automatic logic speed_ok(input logic signed [31:0] v);
      return (v >= `JST_SPEED_MIN && v <= `JST_SPEED_MAX) ||
             (v <= -`JST_SPEED_MIN && v >= -`JST_SPEED_MAX);
   endfunction : speed_ok

   // ==========================================
   // storage and state
   logic [31:0] stage [N];
   logic [31:0] work [N];
   logic [31:0] accel_rate_param;
   logic [31:0] decel_rate_param;
   jst_pkg::jst_state_t state;
   logic refused;
   logic [6:0] pin_s1, pin_s2, pin_s3;
   jst_pkg::jst_pins_t pins;

   // ==========================================
   // write channel
   logic aw_held, w_held, next_aw_held, next_w_held, next_bvalid, wr_fire;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   jst_pkg::jst_region_t wr_reg;
   logic [31:0] wr_val;
   logic wr_bad;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_reg = region_of(aw_addr_q);

   always_comb begin
      wr_val = merge(stage[aw_addr_q[4:2]], w_data_q, w_strb_q);
      wr_bad = 1'b0;
      unique case (wr_reg)
         jst_pkg::JST_R_STAGE: wr_bad = !speed_ok(wr_val);
         jst_pkg::JST_R_ACCEL: wr_val = merge(accel_rate_param, w_data_q, w_strb_q);
         jst_pkg::JST_R_DECEL: wr_val = merge(decel_rate_param, w_data_q, w_strb_q);
         jst_pkg::JST_R_WORK, jst_pkg::JST_R_ACTIVE: wr_bad = 1'b1;
         jst_pkg::JST_R_CMD, jst_pkg::JST_R_STATUS: wr_val = w_data_q & {8'h00, 8'h00, 8'h00,
                                                                         {8{w_strb_q[0]}}};
         jst_pkg::JST_R_NONE: wr_bad = 1'b1;
      endcase
   end

   always_comb begin
      next_aw_held = (aw_held || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
      next_w_held = (w_held || (s_axi_wvalid && s_axi_wready)) && !wr_fire;
      next_bvalid = wr_fire || (s_axi_bvalid && !s_axi_bready);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready <= !next_w_held && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (s_axi_awvalid && s_axi_awready) aw_addr_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bresp <= (wr_reg == jst_pkg::JST_R_NONE) ? RESP_DEC :
                           (wr_bad ? RESP_SLV : RESP_OK);
         end
      end
   end

   // ==========================================
   // commands; only the highest-priority bit of one write acts
   logic cmd_hit, busy, do_commit, do_fetch, nv_start;
   jst_pkg::jst_nvop_t nv_op;
   logic [2:0] nv_idx;
   logic [31:0] nv_rd_word;
   logic nv_rd_strobe, nv_busy;
   assign cmd_hit = wr_fire && wr_reg == jst_pkg::JST_R_CMD && wr_val[4:0] != 5'h00;
   assign busy = state != jst_pkg::JST_IDLE;
   // new table refused while jogging: the running target would jump under the motor
   assign do_commit = cmd_hit && !busy && !jog_active && wr_val[`JST_CMD_WRITE];
   assign do_fetch = cmd_hit && !busy && !wr_val[`JST_CMD_WRITE] &&
                     wr_val[`JST_CMD_READ];

   always_comb begin
      nv_start = 1'b0;
      nv_op = jst_pkg::JST_NV_LOAD;
      if (state == jst_pkg::JST_KICK) begin
         nv_start = 1'b1;
      end else if (cmd_hit && !busy && wr_val[1:0] == 2'b00) begin
         nv_start = 1'b1;
         if (wr_val[`JST_CMD_SAVE]) nv_op = jst_pkg::JST_NV_SAVE;
         else if (wr_val[`JST_CMD_INIT]) nv_op = jst_pkg::JST_NV_ERASE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= jst_pkg::JST_KICK;
      end else begin
         unique case (state)
            jst_pkg::JST_KICK: state <= jst_pkg::JST_WAIT;
            jst_pkg::JST_WAIT: if (!nv_busy) state <= jst_pkg::JST_IDLE;
            jst_pkg::JST_IDLE: if (nv_start) state <= jst_pkg::JST_WAIT;
            default: state <= jst_pkg::JST_IDLE;
         endcase
      end
   end

   // refused-command flag: write one to clear, a new refusal wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         refused <= 1'b0;
      end else if (cmd_hit && (busy || (jog_active && wr_val[`JST_CMD_WRITE]))) begin
         refused <= 1'b1;
      end else if (wr_fire && wr_reg == jst_pkg::JST_R_STATUS && wr_val[`JST_ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   jst_nvstore #(
      .N(N),
      .W(32),
      .WORD_CYC(NV_WORD_CYC)
   ) u_nv (
      .aclk(aclk),
      .aresetn(aresetn),
      .flash_por_n(flash_por_n),
      .start(nv_start),
      .op(nv_op),
      .wr_word(work[nv_idx]),
      .idx(nv_idx),
      .rd_word(nv_rd_word),
      .rd_strobe(nv_rd_strobe),
      .busy(nv_busy)
   );

   // ==========================================
   // tables and rates
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N; i++) stage[i] <= `JST_SPEED_DEFAULT;
      end else if (do_fetch) begin
         for (int i = 0; i < N; i++) stage[i] <= work[i];
      end else if (wr_fire && wr_reg == jst_pkg::JST_R_STAGE && !wr_bad) begin
         stage[aw_addr_q[4:2]] <= wr_val;
      end
   end

   // plain flops: contents do not outlive power, only the flash copy does
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N; i++) work[i] <= `JST_SPEED_DEFAULT;
      end else if (nv_rd_strobe) begin
         work[nv_idx - 3'h1] <= nv_rd_word;
      end else if (do_commit) begin
         for (int i = 0; i < N; i++) work[i] <= stage[i];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accel_rate_param <= `JST_RATE_DEFAULT;
         decel_rate_param <= `JST_RATE_DEFAULT;
      end else if (wr_fire && !wr_bad) begin
         if (wr_reg == jst_pkg::JST_R_ACCEL) accel_rate_param <= wr_val;
         if (wr_reg == jst_pkg::JST_R_DECEL) decel_rate_param <= wr_val;
      end
   end

   // ==========================================
   // pin conditioning: a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1 <= 7'h00;
         pin_s2 <= 7'h00;
         pin_s3 <= 7'h00;
         pins <= '0;
      end else begin
         pin_s1 <= {mode0_sel, home_cmd, jog_forward_cmd, jog_reverse_cmd,
                    speed_select_bit2, speed_select_bit1, speed_select_bit0};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pins <= (pin_s2 & pin_s3) | (pins & (pin_s2 | pin_s3));
      end
   end

   // ==========================================
   // jog selection
   logic mode1, conflict, go_fwd, go_rev;
   assign mode1 = !pins.mode0;
   assign conflict = (pins.home && pins.fwd) || (pins.home && pins.rev) ||
                     (pins.fwd && pins.rev);
   assign go_fwd = mode1 && !busy && !conflict && pins.fwd;
   assign go_rev = mode1 && !busy && !conflict && pins.rev;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         jog_speed_index <= 3'h0;
         jog_speed_target <= `JST_SPEED_DEFAULT;
         jog_velocity_cmd <= 32'h0000_0000;
         jog_ramp_rate <= `JST_RATE_DEFAULT;
         jog_active <= 1'b0;
      end else begin
         jog_speed_index <= pins.sel;
         jog_speed_target <= work[pins.sel];
         jog_active <= go_fwd || go_rev;
         // stopping target is zero; the profile ramps down at the decel rate
         jog_velocity_cmd <= go_fwd ? work[pins.sel] :
                             (go_rev ? 32'(-work[pins.sel]) : 32'h0000_0000);
         jog_ramp_rate <= (go_fwd || go_rev) ? accel_rate_param : decel_rate_param;
      end
   end

   // ==========================================
   // read channel
   logic [31:0] rd_val;
   jst_pkg::jst_region_t rd_reg;
   assign rd_reg = region_of(s_axi_araddr);

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (rd_reg)
         jst_pkg::JST_R_STAGE: rd_val = stage[s_axi_araddr[4:2]];
         jst_pkg::JST_R_WORK: rd_val = work[s_axi_araddr[4:2]];
         jst_pkg::JST_R_STATUS: begin
            rd_val[`JST_ST_BUSY] = busy;
            rd_val[`JST_ST_REFUSED] = refused;
            rd_val[`JST_ST_MODE1] = mode1;
            rd_val[`JST_ST_FWD] = go_fwd;
            rd_val[`JST_ST_REV] = go_rev;
            rd_val[`JST_ST_CONFLICT] = conflict;
            rd_val[`JST_ST_INDEX +: 3] = pins.sel;
         end
         jst_pkg::JST_R_ACTIVE: rd_val = jog_speed_target;
         jst_pkg::JST_R_ACCEL: rd_val = accel_rate_param;
         jst_pkg::JST_R_DECEL: rd_val = decel_rate_param;
         jst_pkg::JST_R_CMD, jst_pkg::JST_R_NONE: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= (rd_reg == jst_pkg::JST_R_NONE) ? RESP_DEC : RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule : jst_table

//--- core/jst_regs.svh
// register map, field positions, reset values and timing counts of the jog speed table
// assumes a 100 MHz aclk and a 32-bit register bus
`ifndef JST_REGS_SVH
`define JST_REGS_SVH
// ==========================================
// table shape and values
`define JST_NUM_ENTRIES 8
`define JST_ENTRY_W 32
`define JST_SPEED_MAX 32'sh0bebc1ff
`define JST_SPEED_MIN 32'sh00000001
`define JST_SPEED_DEFAULT 32'sh000003e8
`define JST_RATE_DEFAULT 32'h000003e8
// ==========================================
// byte offsets
`define JST_OFF_STAGE 8'h00
`define JST_OFF_WORK 8'h20
`define JST_OFF_CMD 8'h40
`define JST_OFF_STATUS 8'h44
`define JST_OFF_ACTIVE 8'h48
`define JST_OFF_ACCEL 8'h4c
`define JST_OFF_DECEL 8'h50
// ==========================================
// command bits
`define JST_CMD_WRITE 0
`define JST_CMD_READ 1
`define JST_CMD_SAVE 2
`define JST_CMD_INIT 3
`define JST_CMD_LOAD 4
// ==========================================
// status bits
`define JST_ST_BUSY 0
`define JST_ST_REFUSED 1
`define JST_ST_MODE1 2
`define JST_ST_FWD 3
`define JST_ST_REV 4
`define JST_ST_CONFLICT 5
`define JST_ST_INDEX 8
// ==========================================
// timing
`define JST_CLK_NS 10
`define JST_NV_WORD_NS 100
`define JST_NV_WORD_CYC ((`JST_NV_WORD_NS + `JST_CLK_NS - 1) / `JST_CLK_NS)
`endif

//--- core/jst_pkg.sv
// types shared by the jog speed table core and its flash store
// assumes jst_regs.svh for all numeric constants
package jst_pkg;
   // ==========================================
   // control states, one-hot
   typedef enum logic [2:0] {
      JST_KICK = 3'b001,
      JST_WAIT = 3'b010,
      JST_IDLE = 3'b100
   } jst_state_t;
   // ==========================================
   // flash store operations
   typedef enum logic [1:0] {
      JST_NV_SAVE = 2'h0,
      JST_NV_ERASE = 2'h1,
      JST_NV_LOAD = 2'h2
   } jst_nvop_t;
   // ==========================================
   // register regions
   typedef enum logic [2:0] {
      JST_R_STAGE, JST_R_WORK, JST_R_CMD, JST_R_STATUS,
      JST_R_ACTIVE, JST_R_ACCEL, JST_R_DECEL, JST_R_NONE
   } jst_region_t;
   // ==========================================
   // conditioned input pins, all active high (on = 1)
   typedef struct packed {
      logic mode0;
      logic home;
      logic fwd;
      logic rev;
      logic [2:0] sel;
   } jst_pins_t;
endpackage : jst_pkg

//--- core/jst_nvstore.sv
// non-volatile copy of the jog speed table, walked one word at a time
// assumes flash_por_n is asserted only at first power-up; aresetn leaves contents alone
`timescale 1ns/1ps
`include "jst_regs.svh"
module jst_nvstore #(
   parameter int N = `JST_NUM_ENTRIES,
   parameter int W = `JST_ENTRY_W,
   parameter int WORD_CYC = `JST_NV_WORD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic flash_por_n,
   input wire logic start,
   input wire jst_pkg::jst_nvop_t op,
   input wire logic [W-1:0] wr_word,
   output logic [$clog2(N)-1:0] idx,
   output logic [W-1:0] rd_word,
   output logic rd_strobe,
   output logic busy
);
   initial begin
      if (N < 2 || WORD_CYC < 1 || WORD_CYC > 255) $error("jst_nvstore: bad parameters");
   end
   logic [W-1:0] mem [N];
   logic [7:0] cyc;
   jst_pkg::jst_nvop_t op_q;
   logic step;
   assign step = busy && (cyc == 8'(WORD_CYC - 1));
   // ==========================================
   // sequencing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy <= 1'b0;
         idx <= '0;
         cyc <= 8'h00;
         op_q <= jst_pkg::JST_NV_LOAD;
      end else if (start && !busy) begin
         busy <= 1'b1;
         idx <= '0;
         cyc <= 8'h00;
         op_q <= op;
      end else if (step) begin
         cyc <= 8'h00;
         idx <= idx + 1'b1;
         if (idx == ($clog2(N))'(N - 1)) begin
            busy <= 1'b0;
         end
      end else if (busy) begin
         cyc <= cyc + 8'h01;
      end
   end
   // ==========================================
   // word read towards the working table
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_strobe <= 1'b0;
         rd_word <= '0;
      end else begin
         rd_strobe <= step && (op_q == jst_pkg::JST_NV_LOAD);
         rd_word <= mem[idx];
      end
   end
   // ==========================================
   // storage; an erased word reads back as the default speed
   always_ff @(posedge aclk) begin
      if (!flash_por_n) begin
         for (int i = 0; i < N; i++) mem[i] <= W'(`JST_SPEED_DEFAULT);
      end else if (step && op_q == jst_pkg::JST_NV_SAVE) begin
         mem[idx] <= wr_word;
      end else if (step && op_q == jst_pkg::JST_NV_ERASE) begin
         mem[idx] <= W'(`JST_SPEED_DEFAULT);
      end
   end
endmodule : jst_nvstore

//--- testbench/jst_table_properties.sv
// port checks of the jog speed table: pin decode, jog outputs, bus holds
// assumes one aclk domain, aresetn synchronous active low
`timescale 1ns/1ps
module jst_table_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic speed_select_bit0,
   input wire logic speed_select_bit1,
   input wire logic speed_select_bit2,
   input wire logic jog_forward_cmd,
   input wire logic jog_reverse_cmd,
   input wire logic home_cmd,
   input wire logic mode0_sel,
   input wire logic [2:0] jog_speed_index,
   input wire logic [31:0] jog_speed_target,
   input wire logic [31:0] jog_velocity_cmd,
   input wire logic jog_active
);
   logic [6:0] pins_now;
   logic [6:0] pins_prev;
   logic [2:0] calm;
   logic settled;
   assign pins_now = {mode0_sel, home_cmd, jog_forward_cmd, jog_reverse_cmd,
      speed_select_bit2, speed_select_bit1, speed_select_bit0};
   // a pin change just after the edge must not count as settled
   assign settled = calm == 3'h7 && pins_now == pins_prev;
   // ====
   // pins need five edges through the synchroniser; seven leaves margin
   always_ff @(posedge aclk) begin
      pins_prev <= pins_now;
      if (!aresetn || pins_now != pins_prev) calm <= 3'h0;
      else if (calm != 3'h7) calm <= calm + 3'h1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ====
   index_from_pins_a: assert property (settled |-> jog_speed_index == pins_now[2:0])
      else $error("index differs from select pins");
   mode0_still_a: assert property (settled && mode0_sel |-> !jog_active)
      else $error("jog active in mode 0");
   conflict_still_a: assert property (settled && $countones(pins_now[5:3]) > 1 |-> !jog_active)
      else $error("jog active with conflicting commands");
   idle_zero_a: assert property (!jog_active |-> jog_velocity_cmd == 32'h0)
      else $error("velocity without jog");
   fwd_speed_a: assert property (settled && jog_active && jog_forward_cmd
      && $stable(jog_speed_target) |-> jog_velocity_cmd == jog_speed_target)
      else $error("forward velocity differs from target");
   rev_speed_a: assert property (settled && jog_active && jog_reverse_cmd
      && $stable(jog_speed_target) |-> jog_velocity_cmd == -jog_speed_target)
      else $error("reverse velocity differs from target");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   active_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h48
      |=> s_axi_rvalid && s_axi_rdata == $past(jog_speed_target))
      else $error("active target read wrong");
   cover property (jog_active && jog_forward_cmd);
   cover property (jog_active && jog_reverse_cmd);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule : jst_table_properties

bind jst_table jst_table_properties jst_table_properties_i (.*);

//--- testbench/jst_host.sv
// host-side partner: selection, jog, home and mode pin levels
// assumes the bench changes want just after an aclk edge
`timescale 1ns/1ps
module jst_host (
   input wire logic servo_off,
   input wire jst_pkg::jst_pins_t want,
   output jst_pkg::jst_pins_t pins
);
   // motion commands held off while the table is rewritten
   assign pins = servo_off ? {want.mode0, 3'h0, want.sel} : want;
endmodule : jst_host

//--- testbench/testbench.sv
// self-checking bench: AXI4-Lite master, pin partner, table expectations
// assumes jst_table built with a one-cycle flash word
`timescale 1ns/1ps
`include "jst_regs.svh"
module testbench;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic flash_por_n = 1'h0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, jog_active;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, jog_speed_target, jog_velocity_cmd, jog_ramp_rate, d, acc;
   logic [2:0] jog_speed_index;
   jst_pkg::jst_pins_t want = '0;
   jst_pkg::jst_pins_t pins;
   logic servo_off = 1'h1;
   logic [31:0] seed = 32'h0000b699;
   logic [31:0] ex [8];
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   jst_host jst_host_i (.servo_off(servo_off), .want(want), .pins(pins));
   jst_table #(.NV_WORD_CYC(1)) jst_table_i (.*, .speed_select_bit0(pins.sel[0]),
      .speed_select_bit1(pins.sel[1]), .speed_select_bit2(pins.sel[2]),
      .jog_forward_cmd(pins.fwd), .jog_reverse_cmd(pins.rev), .home_cmd(pins.home),
      .mode0_sel(pins.mode0));
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ====
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] spd(input logic [31:0] x);
      logic [31:0] m;
      m = x % `JST_SPEED_MAX + 32'h1;
      return x[31] ? -m : m;
   endfunction : spd
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rsp);
      logic ad;
      logic wd;
      ad = 1'h0;
      wd = 1'h0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (s_axi_awready && !ad) s_axi_awvalid <= 1'h0;
         if (s_axi_wready && !wd) s_axi_wvalid <= 1'h0;
         ad = ad | s_axi_awready;
         wd = wd | s_axi_wready;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rsp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : axr
   task automatic idle();
      do axr(8'h44, d, r); while (d[0] !== 1'h0);
   endtask : idle
   // flash contents survive unless keep is low
   task automatic boot(input logic keep);
      aresetn <= 1'h0;
      flash_por_n <= keep;
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      flash_por_n <= 1'h1;
      idle();
   endtask : boot
   task automatic tbl(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         axr(b + 8'(4 * i), d, r);
         chk("entry", ex[i], d);
      end
   endtask : tbl
   // ten edges: outputs settle after five, checker needs the pins calm for longer
   task automatic pin(input logic m, h, f, v, input logic [2:0] s);
      want <= '{m, h, f, v, s};
      repeat (10) @(posedge aclk);
   endtask : pin
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // ====
   initial begin
      boot(1'h0);
      for (int i = 0; i < 8; i++) ex[i] = `JST_SPEED_DEFAULT;
      tbl(8'h00);
      tbl(8'h20);
      $display("test defaults done");
      for (int i = 0; i < 8; i++) ex[i] = spd(rnd());
      ex[0] = 32'h1;
      ex[7] = -`JST_SPEED_MAX;
      for (int i = 0; i < 8; i++) axw(8'(4 * i), ex[i], r);
      axw(8'h04, 32'h0bebc200, r);
      chk("range bresp", 32'h2, {30'h0, r});
      axw(8'h40, 32'h1, r);
      tbl(8'h20);
      $display("test write done");
      acc = rnd();
      axw(8'h4c, acc, r);
      servo_off <= 1'h0;
      for (int k = 0; k < 16; k++) begin
         pin(1'h0, 1'h0, !k[3], k[3], k[2:0]);
         chk("index", 32'(k[2:0]), {29'h0, jog_speed_index});
         chk("target", ex[k[2:0]], jog_speed_target);
         chk("velocity", k[3] ? -ex[k[2:0]] : ex[k[2:0]], jog_velocity_cmd);
         chk("ramp", acc, jog_ramp_rate);
      end
      axr(8'h48, d, r);
      chk("active", ex[7], d);
      axw(8'h40, 32'h1, r);
      axr(8'h44, d, r);
      chk("refused", 32'h1, {31'h0, d[1]});
      axw(8'h44, 32'h2, r);
      axr(8'h44, d, r);
      chk("refused clear", 32'h0, {31'h0, d[1]});
      pin(1'h0, 1'h1, 1'h1, 1'h0, 3'h5);
      chk("conflict", 32'h0, {31'h0, jog_active});
      pin(1'h1, 1'h0, 1'h1, 1'h0, 3'h5);
      chk("mode0", 32'h0, {31'h0, jog_active});
      pin(1'h0, 1'h0, 1'h0, 1'h0, 3'h0);
      chk("ramp", 32'h3e8, jog_ramp_rate);
      servo_off <= 1'h1;
      $display("test jog done");
      axw(8'h40, 32'h4, r);
      idle();
      for (int i = 0; i < 8; i++) axw(8'(4 * i), spd(rnd()), r);
      axw(8'h40, 32'h1, r);
      axw(8'h40, 32'h10, r);
      idle();
      tbl(8'h20);
      boot(1'h1);
      tbl(8'h20);
      axw(8'h40, 32'h2, r);
      tbl(8'h00);
      axw(8'h40, 32'h8, r);
      idle();
      boot(1'h1);
      for (int i = 0; i < 8; i++) ex[i] = `JST_SPEED_DEFAULT;
      tbl(8'h20);
      $display("test flash done");
      report_and_stop();
   end
endmodule : testbench
